// ==== common/pbs_defines.svh ====
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// ==========================================
// geometry
`define PBS_ADDR_W         13
`define PBS_DATA_W         8
`define PBS_MEM_DEPTH      8192
`define PBS_LAST_ADDR      13'h1fff
`define PBS_ERASED         8'h00
`define PBS_OPTION_ADDR    13'h1fdf
`define PBS_LOCK_BIT       3
// ==========================================
// implemented prom ranges
`define PBS_PROM0_LO       13'h0020
`define PBS_PROM0_HI       13'h004f
`define PBS_PROM1_LO       13'h0100
`define PBS_PROM1_HI       13'h1eff
`define PBS_PROM2_LO       13'h1ff0
`define PBS_PROM2_HI       13'h1fff
// ==========================================
// selector codes {d,c,b,a}
`define PBS_SEL_PROG       4'h0
`define PBS_SEL_VERIFY     4'h4
`define PBS_SEL_LOCK_VER   4'h5
`define PBS_SEL_LOCK_DUMP  4'h7
`define PBS_SEL_LOAD       4'h2
`define PBS_SEL_RUN        4'h8
`define PBS_SEL_DUMP       4'h6
// ==========================================
// timing
`define PBS_CLK_PERIOD_NS  4
`define PBS_LOCK_TIME_NS   1000000000
`define PBS_PROG_TIME_NS   1000000
`define PBS_BIT_TIME_NS    208333
`define PBS_EXT_WAIT       3
// ==========================================
// register map, byte addresses
`define PBS_REG_CTRL       6'h00
`define PBS_REG_STATUS     6'h04
`define PBS_REG_FAIL       6'h08
`define PBS_REG_PTIME      6'h0c
`define PBS_REG_PCTL       6'h1c
`define PBS_CTRL_ERASE     0
`define PBS_PCTL_LATCH     2
`define PBS_PCTL_VOLT      0
`endif

// ==== common/pbs_pkg.sv ====
`include "pbs_defines.svh"
package pbs_pkg;
  typedef enum logic [2:0] {
    RT_PROG, RT_VERIFY, RT_LOCK_VER, RT_LOCK_DUMP, RT_LOAD, RT_RUN, RT_DUMP, RT_NONE
  } pbs_routine_t;
  typedef enum logic [4:0] {
    ST_SAMPLE, ST_ERASE, ST_P_ADDR, ST_P_LATCH, ST_P_VOLT, ST_P_WAIT, ST_P_END,
    ST_V_ADDR, ST_V_CMP, ST_D_ADDR, ST_D_SEND, ST_L_LATCH, ST_L_VOLT, ST_L_WAIT,
    ST_L_HOLD, ST_DONE, ST_FAIL, ST_IDLE
  } pbs_state_t;
  typedef struct packed {
    logic                       we;
    logic [`PBS_ADDR_W-1:0]     addr;
    logic [`PBS_DATA_W-1:0]     wdata;
  } pbs_mem_req_t;
endpackage

// ==== dv/pbs_eprom_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// external source image, one byte per address
module pbs_eprom_model (
  input  wire logic [12:0] ext_addr,
  input  wire logic [3:0]  key_nib,
  input  wire logic [7:0]  key_byte,
  input  wire logic [12:0] bad_addr,
  input  wire logic        bad_en,
  output logic [7:0]       ext_data
);
  logic [7:0] img;
  always_comb begin
    // sparse image, unused bytes left zero for a faster pass
    img = (ext_addr[3:0] == key_nib) ? ((ext_addr[7:0] ^ key_byte) | 8'h01) : 8'h00;
    // one corrupted byte only when the bench asks for a mismatch
    ext_data = (bad_en && ext_addr == bad_addr) ? ~img : img;
  end
endmodule
`default_nettype wire

// ==== dv/prom_bootstrap_program_sequencer_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pbs_defines.svh"
module prom_bootstrap_program_sequencer_test;
  localparam int LOCK_CYC = 2000;
  logic        ref_clk, sys_rst, vpp_present, bad_en, loader_enable, txd;
  logic        red_led, green_led, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  routine_select, key_nib;
  logic [7:0]  ext_data, key_byte;
  logic [12:0] ext_addr, bad_addr;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, st;
  int          fails, n_tests, rel_cyc, red_seen, mode;
  int          cyc = 0;
  logic [3:0]  codes [7] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'h2, 4'h8, 4'h6};

  // short source wait keeps the full passes inside the cycle budget
  pbs_seq #(.EXT_WAIT(1), .PROG_CYCLES(4), .LOCK_CYCLES(LOCK_CYC), .BAUD_DIV(4)) dut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .ROUTINE_SELECT(routine_select),
    .VPP_PRESENT(vpp_present), .EXT_ADDR(ext_addr), .EXT_DATA(ext_data),
    .RED_LED(red_led), .GREEN_LED(green_led), .TXD(txd), .LOADER_ENABLE(loader_enable),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest));
  pbs_eprom_model eprom (.ext_addr(ext_addr), .key_nib(key_nib), .key_byte(key_byte),
    .bad_addr(bad_addr), .bad_en(bad_en), .ext_data(ext_data));

  // ==========================================
  // helpers
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  function automatic logic in_prom(input logic [12:0] a);
    return (a >= 13'h0020 && a <= 13'h004f) || (a >= 13'h0100 && a <= 13'h1eff) ||
           (a >= 13'h1ff0);
  endfunction
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    // hold until waitrequest is seen low at a rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) fails++;
  endtask
  // selectors settle under reset, then release starts the routine
  task automatic rst(input logic [3:0] sel, input logic vpp);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    routine_select <= sel;
    vpp_present <= vpp;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rel_cyc = cyc;
  endtask
  task automatic wait_end(output logic [31:0] s);
    int n = 0;
    do begin
      bus(1'b0, `PBS_REG_STATUS, 32'h0, s);
      n++;
    end while (s[4:0] !== pbs_pkg::ST_DONE && s[4:0] !== pbs_pkg::ST_FAIL &&
               s[4:0] !== pbs_pkg::ST_IDLE && n < 60000);
  endtask

  // ==========================================
  // clock, watchdog, pin monitor
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (!sys_rst) begin
      if (mode == 1 && ext_addr != 13'h0 && !in_prom(ext_addr)) check(ext_addr, 32'h0);
      if (mode == 1 && red_led === 1'b1) red_seen++;
      if (mode == 1) check(red_led & green_led, 32'h0);
      if (mode == 2) check(red_led, 32'h0);
      if (mode == 3) check({red_led, green_led}, 32'h0);
      if (mode == 3) check(txd, 32'h1);
    end
  end

  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    routine_select = 4'h8;
    vpp_present = 1'b0;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    bad_en = 1'b0;
    bad_addr = 13'h0;
    key_nib = 4'h0;
    key_byte = 8'h0;
    fails = 0;
    n_tests = 0;
    mode = 0;
    red_seen = 0;
    void'($urandom(74670));
    key_nib = 4'($urandom());
    key_byte = 8'($urandom());
    for (int i = 0; i < 7; i++) begin
      rst(codes[i], 1'b0);
      bus(1'b0, `PBS_REG_STATUS, 32'h0, st);
      check(st[8:5], i);
    end
    rst(4'h8, 1'b0);
    bus(1'b0, `PBS_REG_PTIME, 32'h0, st);
    check(st, 32'h4);
    bus(1'b1, 6'h10, 32'hffffffff, st);
    bus(1'b0, 6'h10, 32'h0, st);
    check(st, 32'h0);
    // voltage enable cannot be forced from the bus
    bus(1'b1, `PBS_REG_PCTL, 32'h1, st);
    bus(1'b0, `PBS_REG_PCTL, 32'h0, st);
    check(st, 32'h0);
    bus(1'b1, `PBS_REG_CTRL, 32'h1, st);
    wait_end(st);
    check(st[11], 32'h0);
    check(loader_enable, 32'h1);
    // program then automatic verify
    mode = 1;
    rst(4'h0, 1'b1);
    wait_end(st);
    check(st[4:0], pbs_pkg::ST_DONE);
    check({red_led, green_led}, 32'h1);
    check(red_seen > 0, 32'h1);
    bus(1'b0, `PBS_REG_PCTL, 32'h0, st);
    check(st, 32'h0);
    // verify-only with one corrupted source byte
    bad_addr = 13'h0100 + 13'($urandom_range(255));
    bad_en = 1'b1;
    mode = 2;
    rst(4'h4, 1'b1);
    wait_end(st);
    check(st[4:0], pbs_pkg::ST_FAIL);
    bus(1'b0, `PBS_REG_FAIL, 32'h0, st);
    check(st, bad_addr);
    repeat (20) @(posedge ref_clk);
    check(ext_addr, bad_addr);
    check(green_led, 32'h0);
    // lock after verify, then a locked part must refuse verify
    bad_en = 1'b0;
    mode = 3;
    rst(4'h5, 1'b1);
    wait_end(st);
    check(st[4:0], pbs_pkg::ST_DONE);
    check(cyc - rel_cyc >= LOCK_CYC, 32'h1);
    check(st[11], 32'h1);
    check(loader_enable, 32'h0);
    mode = 2;
    rst(4'h4, 1'b1);
    wait_end(st);
    check(st[4:0], pbs_pkg::ST_FAIL);
    check(green_led, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== logic/pbs_prom.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pbs_defines.svh"
// ==========================================
// internal one-time-programmable array
module pbs_prom #(
  parameter int DEPTH = `PBS_MEM_DEPTH
) (
  input  wire logic                   REF_CLK,
  input  wire logic                   CLK_EN,
  input  wire pbs_pkg::pbs_mem_req_t  req,
  output logic [`PBS_DATA_W-1:0]      rdata
);
  // nonvolatile: no reset, contents undefined until erased
  logic [`PBS_DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge REF_CLK) begin
    if (CLK_EN) begin
      if (req.we) begin
        mem[req.addr] <= req.wdata;
      end
      rdata <= mem[req.addr];
    end
  end
endmodule
`default_nettype wire

// ==== logic/pbs_seq.sv ====
// Summary of operation
// - selectors at reset release pick the routine
// - copy whole 8K external image, same addresses
// - skip addresses without internal prom
// - red lit while programming, then verify
// - all bytes match lights green, done
// - verify compares internal byte with external
// - verify-only keeps red off throughout
// - mismatch halts, failing address held, green off
// - lock routines program only lock, need supply
// - locked part refuses verify and dump
// - lock-and-verify verifies first, then locks
// - lock-and-dump uploads serially, then locks
// - no indicator during lock routines
// - lock routines take about one second
// - locked disables loader, single-chip only
// - voltage enable needs latch enable set
// - erased byte reads zero
`timescale 1ns/1ns
`default_nettype none
`include "pbs_defines.svh"
module pbs_seq #(
  parameter int EXT_WAIT    = `PBS_EXT_WAIT,
  parameter int PROG_CYCLES = (`PBS_PROG_TIME_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS,
  parameter int LOCK_CYCLES = `PBS_LOCK_TIME_NS / `PBS_CLK_PERIOD_NS,
  parameter int BAUD_DIV    = `PBS_BIT_TIME_NS / `PBS_CLK_PERIOD_NS
) (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic [3:0]  ROUTINE_SELECT,
  input  wire logic        VPP_PRESENT,
  output logic [12:0]      EXT_ADDR,
  input  wire logic [7:0]  EXT_DATA,
  output logic             RED_LED,
  output logic             GREEN_LED,
  output logic             TXD,
  output logic             LOADER_ENABLE,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST
);
  // ==========================================
  // decoders
  function automatic logic is_prom(input logic [12:0] a);
    is_prom = (a >= `PBS_PROM0_LO && a <= `PBS_PROM0_HI) ||
              (a >= `PBS_PROM1_LO && a <= `PBS_PROM1_HI) ||
              (a >= `PBS_PROM2_LO && a <= `PBS_PROM2_HI);
  endfunction

  function automatic pbs_pkg::pbs_routine_t decode(input logic [3:0] s);
    case (s)
      `PBS_SEL_PROG:      decode = pbs_pkg::RT_PROG;
      `PBS_SEL_VERIFY:    decode = pbs_pkg::RT_VERIFY;
      `PBS_SEL_LOCK_VER:  decode = pbs_pkg::RT_LOCK_VER;
      `PBS_SEL_LOCK_DUMP: decode = pbs_pkg::RT_LOCK_DUMP;
      `PBS_SEL_LOAD:      decode = pbs_pkg::RT_LOAD;
      `PBS_SEL_RUN:       decode = pbs_pkg::RT_RUN;
      `PBS_SEL_DUMP:      decode = pbs_pkg::RT_DUMP;
      default:            decode = pbs_pkg::RT_NONE;
    endcase
  endfunction

  // ==========================================
  // declarations
  pbs_pkg::pbs_state_t   state, next_state, end_state;
  pbs_pkg::pbs_routine_t routine, next_routine;
  pbs_pkg::pbs_mem_req_t mreq;
  logic [12:0] addr, next_addr, fail_addr, next_fail_addr, next_ext;
  logic [31:0] cnt, next_cnt, lock_timer, next_lock_timer, ptime, next_ptime;
  logic [7:0]  dlat, next_dlat, mem_rdata;
  logic        lock, next_lock, latch_en, next_latch, volt_en, next_volt;
  logic        next_red, next_green, step, tx_start, erase_take, erase_req;
  logic        next_erase_req, next_wait, next_loader;
  logic [31:0] next_rdata;
  logic        tx_busy, next_tx_busy;
  logic [9:0]  tx_sh, next_tx_sh;
  logic [3:0]  tx_bits, next_tx_bits;
  logic [31:0] tx_div, next_tx_div;
  logic        locking;

  assign locking = routine == pbs_pkg::RT_LOCK_VER || routine == pbs_pkg::RT_LOCK_DUMP;

  pbs_prom u_prom (
    .REF_CLK (REF_CLK),
    .CLK_EN  (CLK_EN),
    .req     (mreq),
    .rdata   (mem_rdata)
  );

  // ==========================================
  // sequencer
  always_comb begin
    next_state      = state;
    next_routine    = routine;
    next_addr       = addr;
    next_cnt        = cnt;
    next_lock       = lock;
    next_latch      = latch_en;
    next_volt       = volt_en;
    next_dlat       = dlat;
    next_red        = RED_LED;
    next_green      = GREEN_LED;
    next_fail_addr  = fail_addr;
    next_ext        = EXT_ADDR;
    next_lock_timer = (&lock_timer) ? lock_timer : lock_timer + 32'h1;
    tx_start        = 1'b0;
    erase_take      = 1'b0;
    step            = 1'b0;
    end_state       = pbs_pkg::ST_IDLE;
    mreq            = '0;
    mreq.addr       = addr;
    case (state)
      pbs_pkg::ST_SAMPLE: begin
        next_routine = decode(ROUTINE_SELECT);
        next_addr    = '0;
        next_cnt     = '0;
        case (decode(ROUTINE_SELECT))
          pbs_pkg::RT_PROG: begin
            next_red   = 1'b1;
            next_state = pbs_pkg::ST_P_ADDR;
          end
          pbs_pkg::RT_VERIFY:
            next_state = lock ? pbs_pkg::ST_FAIL : pbs_pkg::ST_V_ADDR;
          pbs_pkg::RT_LOCK_VER:
            next_state = lock ? pbs_pkg::ST_L_LATCH : pbs_pkg::ST_V_ADDR;
          pbs_pkg::RT_LOCK_DUMP:
            next_state = lock ? pbs_pkg::ST_L_LATCH : pbs_pkg::ST_D_ADDR;
          default:
            next_state = pbs_pkg::ST_IDLE;
        endcase
      end
      pbs_pkg::ST_ERASE: begin
        mreq.we    = 1'b1;
        mreq.wdata = `PBS_ERASED;
        step       = 1'b1;
        if (addr == `PBS_LAST_ADDR) begin
          next_lock = 1'b0;
        end
      end
      pbs_pkg::ST_P_ADDR: begin
        end_state = pbs_pkg::ST_V_ADDR;
        if (!is_prom(addr)) begin
          step = 1'b1;
        end else if (cnt != 32'(EXT_WAIT)) begin
          // unmapped addresses never reach the source bus
          next_ext = addr;
          next_cnt = cnt + 32'h1;
        end else begin
          next_cnt  = '0;
          next_dlat = EXT_DATA;
          if (EXT_DATA == `PBS_ERASED) begin
            step = 1'b1;
          end else begin
            next_state = pbs_pkg::ST_P_LATCH;
          end
        end
        if (step && addr == `PBS_LAST_ADDR) begin
          next_red = 1'b0;
        end
      end
      pbs_pkg::ST_P_LATCH: begin
        next_latch = 1'b1;
        next_state = pbs_pkg::ST_P_VOLT;
      end
      pbs_pkg::ST_P_VOLT: begin
        next_volt  = latch_en;
        next_state = pbs_pkg::ST_P_WAIT;
      end
      pbs_pkg::ST_P_WAIT: begin
        next_cnt = cnt + 32'h1;
        if (cnt + 32'h1 >= ptime) begin
          mreq.we    = volt_en && VPP_PRESENT;
          mreq.wdata = dlat;
          next_cnt   = '0;
          next_state = pbs_pkg::ST_P_END;
        end
      end
      pbs_pkg::ST_P_END: begin
        next_latch = 1'b0;
        next_volt  = 1'b0;
        next_state = pbs_pkg::ST_P_ADDR;
        end_state  = pbs_pkg::ST_V_ADDR;
        step       = 1'b1;
        if (addr == `PBS_LAST_ADDR) begin
          next_red = 1'b0;
        end
      end
      pbs_pkg::ST_V_ADDR: begin
        if (!is_prom(addr)) begin
          step      = 1'b1;
          end_state = locking ? pbs_pkg::ST_L_LATCH : pbs_pkg::ST_DONE;
          if (addr == `PBS_LAST_ADDR && !locking) begin
            next_green = 1'b1;
          end
        end else if (cnt != 32'(EXT_WAIT)) begin
          next_ext = addr;
          next_cnt = cnt + 32'h1;
        end else begin
          next_cnt   = '0;
          next_state = pbs_pkg::ST_V_CMP;
        end
      end
      pbs_pkg::ST_V_CMP: begin
        if (mem_rdata != EXT_DATA) begin
          next_fail_addr = addr;
          next_state     = pbs_pkg::ST_FAIL;
        end else begin
          step       = 1'b1;
          next_state = pbs_pkg::ST_V_ADDR;
          end_state  = locking ? pbs_pkg::ST_L_LATCH : pbs_pkg::ST_DONE;
          if (addr == `PBS_LAST_ADDR && !locking) begin
            next_green = 1'b1;
          end
        end
      end
      pbs_pkg::ST_D_ADDR: begin
        end_state = pbs_pkg::ST_L_LATCH;
        if (!is_prom(addr)) begin
          step = 1'b1;
        end else if (cnt == '0) begin
          next_ext = addr;
          next_cnt = 32'h1;
        end else begin
          next_cnt   = '0;
          tx_start   = 1'b1;
          next_state = pbs_pkg::ST_D_SEND;
        end
      end
      pbs_pkg::ST_D_SEND: begin
        if (!tx_busy) begin
          step       = 1'b1;
          next_state = pbs_pkg::ST_D_ADDR;
          end_state  = pbs_pkg::ST_L_LATCH;
        end
      end
      pbs_pkg::ST_L_LATCH: begin
        next_latch = 1'b1;
        next_state = pbs_pkg::ST_L_VOLT;
      end
      pbs_pkg::ST_L_VOLT: begin
        next_volt  = latch_en;
        next_state = pbs_pkg::ST_L_WAIT;
      end
      pbs_pkg::ST_L_WAIT: begin
        next_cnt = cnt + 32'h1;
        if (cnt + 32'h1 >= ptime) begin
          // only the lock cell is touched, never the array
          if (volt_en && VPP_PRESENT) begin
            next_lock = 1'b1;
          end
          next_cnt   = '0;
          next_state = pbs_pkg::ST_L_HOLD;
        end
      end
      pbs_pkg::ST_L_HOLD: begin
        next_latch = 1'b0;
        next_volt  = 1'b0;
        if (lock_timer >= 32'(LOCK_CYCLES)) begin
          next_state = pbs_pkg::ST_DONE;
        end
      end
      pbs_pkg::ST_DONE, pbs_pkg::ST_FAIL, pbs_pkg::ST_IDLE: begin
        if (erase_req) begin
          erase_take = 1'b1;
          next_green = 1'b0;
          next_addr  = '0;
          next_state = pbs_pkg::ST_ERASE;
        end
      end
      default: next_state = pbs_pkg::ST_IDLE;
    endcase
    if (step) begin
      if (addr == `PBS_LAST_ADDR) begin
        next_addr  = '0;
        next_state = end_state;
      end else begin
        next_addr = addr + 13'h1;
      end
    end
  end

  // lock cell is nonvolatile: reset leaves it alone
  always_ff @(posedge REF_CLK) begin
    if (CLK_EN) begin
      lock <= next_lock;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state         <= pbs_pkg::ST_SAMPLE;
      routine       <= pbs_pkg::RT_NONE;
      addr          <= '0;
      cnt           <= '0;
      latch_en      <= 1'b0;
      volt_en       <= 1'b0;
      dlat          <= '0;
      RED_LED       <= 1'b0;
      GREEN_LED     <= 1'b0;
      fail_addr     <= '0;
      EXT_ADDR      <= '0;
      lock_timer    <= '0;
      LOADER_ENABLE <= 1'b0;
    end else if (CLK_EN) begin
      state         <= next_state;
      routine       <= next_routine;
      addr          <= next_addr;
      cnt           <= next_cnt;
      latch_en      <= next_latch;
      volt_en       <= next_volt;
      dlat          <= next_dlat;
      RED_LED       <= next_red;
      GREEN_LED     <= next_green;
      fail_addr     <= next_fail_addr;
      EXT_ADDR      <= next_ext;
      lock_timer    <= next_lock_timer;
      LOADER_ENABLE <= next_loader;
    end
  end

  assign next_loader = !lock;

  // ==========================================
  // serial upload, 8 data bits, one stop bit
  always_comb begin
    next_tx_sh   = tx_sh;
    next_tx_bits = tx_bits;
    next_tx_div  = tx_div;
    next_tx_busy = tx_busy;
    if (tx_start) begin
      next_tx_sh   = {1'b1, mem_rdata, 1'b0};
      next_tx_bits = 4'd10;
      next_tx_div  = '0;
      next_tx_busy = 1'b1;
    end else if (tx_busy) begin
      next_tx_div = tx_div + 32'h1;
      if (tx_div + 32'h1 >= 32'(BAUD_DIV)) begin
        next_tx_div  = '0;
        next_tx_sh   = {1'b1, tx_sh[9:1]};
        next_tx_bits = tx_bits - 4'd1;
        next_tx_busy = tx_bits != 4'd1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tx_sh   <= 10'h3ff;
      tx_bits <= '0;
      tx_div  <= '0;
      tx_busy <= 1'b0;
    end else if (CLK_EN) begin
      tx_sh   <= next_tx_sh;
      tx_bits <= next_tx_bits;
      tx_div  <= next_tx_div;
      tx_busy <= next_tx_busy;
    end
  end

  assign TXD = tx_sh[0];

  // ==========================================
  // register slave, answers one cycle after the request
  always_comb begin
    next_wait      = 1'b1;
    next_rdata     = AVS_READDATA;
    next_ptime     = ptime;
    next_erase_req = erase_req && !erase_take;
    if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
      next_wait  = 1'b0;
      next_rdata = '0;
      case (AVS_ADDRESS)
        `PBS_REG_STATUS:
          next_rdata = {20'h0, lock, GREEN_LED, RED_LED, 4'(routine),
                        5'(state)};
        `PBS_REG_FAIL:  next_rdata = {19'h0, fail_addr};
        `PBS_REG_PTIME: next_rdata = ptime;
        `PBS_REG_PCTL:
          next_rdata = {29'h0, latch_en, 1'b0, volt_en};
        default:        next_rdata = '0;
      endcase
    end
    if (AVS_WRITE && !AVS_WAITREQUEST) begin
      if (AVS_ADDRESS == `PBS_REG_PTIME) begin
        for (int i = 0; i < 4; i++) begin
          if (AVS_BYTEENABLE[i]) next_ptime[8*i+:8] = AVS_WRITEDATA[8*i+:8];
        end
      end
      if (AVS_ADDRESS == `PBS_REG_CTRL && AVS_BYTEENABLE[0] &&
          AVS_WRITEDATA[`PBS_CTRL_ERASE]) begin
        next_erase_req = 1'b1; // set wins over the take
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= '0;
      ptime           <= 32'(PROG_CYCLES);
      erase_req       <= 1'b0;
    end else if (CLK_EN) begin
      AVS_WAITREQUEST <= next_wait;
      AVS_READDATA    <= next_rdata;
      ptime           <= next_ptime;
      erase_req       <= next_erase_req;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  a_volt_needs_latch: assert property (volt_en |-> latch_en)
    else $error("voltage enable without latch");
  a_red_prog_only: assert property (RED_LED |-> routine == pbs_pkg::RT_PROG)
    else $error("red lit outside programming");
  a_dark_locking: assert property (locking |-> !RED_LED && !GREEN_LED)
    else $error("indicator lit in lock routine");
  a_write_mapped: assert property (mreq.we && state != pbs_pkg::ST_ERASE |->
    is_prom(mreq.addr)) else $error("write outside prom");
  a_skip_erased: assert property (mreq.we && state != pbs_pkg::ST_ERASE |->
    mreq.wdata != `PBS_ERASED && volt_en) else $error("needless program cycle");
  a_prog_then_ver: assert property (state == pbs_pkg::ST_P_END && CLK_EN &&
    addr == `PBS_LAST_ADDR |=> state == pbs_pkg::ST_V_ADDR && !RED_LED)
    else $error("verify not started after program");
  a_fail_holds: assert property (state == pbs_pkg::ST_FAIL |->
    !GREEN_LED && EXT_ADDR == fail_addr)
    else $error("fail address not held");
  a_green_cause: assert property ($rose(GREEN_LED) |->
    $past(state) inside {pbs_pkg::ST_V_CMP, pbs_pkg::ST_V_ADDR})
    else $error("green without verify");
  a_lock_refuse: assert property (state == pbs_pkg::ST_SAMPLE && CLK_EN &&
    lock && decode(ROUTINE_SELECT) == pbs_pkg::RT_VERIFY |=>
    state == pbs_pkg::ST_FAIL) else $error("locked part verified");
  a_lock_time: assert property (state == pbs_pkg::ST_DONE && locking |->
    lock_timer >= 32'(LOCK_CYCLES)) else $error("lock routine too short");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST &&
    CLK_EN |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer late");

  c_prog_pass: cover property (routine == pbs_pkg::RT_PROG && $rose(GREEN_LED));
  c_verify_fail: cover property ($rose(state == pbs_pkg::ST_FAIL));
  c_lock_done: cover property (locking && $rose(state == pbs_pkg::ST_DONE));
endmodule
`default_nettype wire
